//--- pllsr_regs.svh
// Purpose: register indices, field positions, reset values of the status bank
// Assumes: byte address is four times the index
// Notes:   definitions only
`ifndef PLLSR_REGS_SVH
`define PLLSR_REGS_SVH

`define PLLSR_AW            12
`define PLLSR_IW            10
`define PLLSR_IDX_REFMON    10'h01A
`define PLLSR_IDX_HOLDOVER  10'h01D
`define PLLSR_IDX_STATUS    10'h01F
`define PLLSR_IDX_EVENT     10'h020
`define PLLSR_IDX_MASK      10'h021

`define PLLSR_NMON          7
`define PLLSR_BIT_CALDONE   6
`define PLLSR_BIT_HOLDACT   5
`define PLLSR_BIT_SECSEL    4
`define PLLSR_BIT_VCOTHR    3
`define PLLSR_BIT_SECTHR    2
`define PLLSR_BIT_FIRSTTHR  1
`define PLLSR_BIT_LOCK      0

`define PLLSR_BIT_THRSEL    6
`define PLLSR_BIT_RBDIS     4
`define PLLSR_BIT_HOLDEN    2
`define PLLSR_BIT_HOLDEN2   0

`define PLLSR_RST_MON       7'h00
`define PLLSR_RST_MASK      7'h00
`define PLLSR_RST_BIT       1'b0
`define PLLSR_RST_DATA      32'h0000_0000

`endif

//--- pllsr_pkg.sv
// Purpose: types of the pll status readback bank
// Assumes: constants come from pllsr_regs.svh
// Notes:   monitor struct order equals status bit order
package pllsr_pkg;

   // analog and controller conditions, msb = status bit 6
   typedef struct packed {
      logic calDone;
      logic holdoverActive;
      logic secondRefSelected;
      logic vcoAboveThreshold;
      logic secondRefAboveThreshold;
      logic firstRefAboveThreshold;
      logic lockDetect;
   } pllsrMon_t;

   // configuration that steers the analog side
   typedef struct packed {
      logic holdoverEnable;
      logic refThresholdSelect;
   } pllsrCtl_t;

   typedef struct packed {
      logic [6:0]  sync1;
      logic [6:0]  sync2;
      logic [6:0]  sync3;
      logic [6:0]  live;
      logic [6:0]  events;
      logic [6:0]  mask;
      logic        holdEnA;
      logic        holdEnB;
      logic        readbackOff;
      logic        thrSel;
      logic        irq;
      logic [31:0] rdata;
      logic        slvErr;
   } pllsrState_t;

endpackage : pllsr_pkg

//--- pllsr_status.sv
// Purpose: pll status register, holdover enables, monitor event interrupt
// Assumes: APB3 slave, zero wait states; monitor inputs are asynchronous
// Notes:   status bits are live, writes to the status register are ignored
//
// Chosen here: register access over APB.
`timescale 1ns/10ps
`default_nettype none
`include "pllsr_regs.svh"

module pllsr_status
   import pllsr_pkg::*;
(
   input  wire logic                  sys_clk,
   input  wire logic                  reset,
   input  wire logic                  psel,
   input  wire logic                  penable,
   input  wire logic                  pwrite,
   input  wire logic [`PLLSR_AW-1:0]  paddr,
   input  wire logic [31:0]           pwdata,
   output logic                       pready,
   output logic      [31:0]           prdata,
   output logic                       pslverr,
   input  wire pllsrMon_t             monIn,
   output pllsrCtl_t                  ctlOut,
   output logic                       irq
);

   pllsrState_t               s_q;
   pllsrState_t               s_d;
   logic [`PLLSR_NMON-1:0]    filt;
   logic [`PLLSR_IW-1:0]      idx;
   logic                      aligned;
   logic                      setup;
   logic                      wrAcc;
   logic [31:0]               statusWord;

   assign idx     = paddr[`PLLSR_AW-1:2];
   assign aligned = (paddr[1:0] == 2'h0);
   assign setup   = psel & ~penable;
   assign wrAcc   = psel & penable & pwrite;

   // a change counts once the second and third stages agree
   genvar g;
   generate
      for (g = 0; g < `PLLSR_NMON; g++) begin : gFilt
         assign filt[g] = (s_q.sync2[g] == s_q.sync3[g]) ?
                          s_q.sync3[g] : s_q.live[g];
      end
   endgenerate

   always_comb begin
      statusWord = 32'h0000_0000;
      statusWord[`PLLSR_NMON-1:0] = s_q.live;
   end

   always_comb begin
      s_d        = s_q;
      s_d.sync1  = monIn;
      s_d.sync2  = s_q.sync1;
      s_d.sync3  = s_q.sync2;
      s_d.live   = filt;

      // any edge of a live condition is an event; set beats clear
      s_d.events = s_q.events;
      if (wrAcc && aligned && idx == `PLLSR_IDX_EVENT) begin
         s_d.events = s_q.events & ~pwdata[`PLLSR_NMON-1:0];
      end
      s_d.events = s_d.events | (filt ^ s_q.live);

      if (wrAcc && aligned) begin
         case (idx)
            `PLLSR_IDX_REFMON: begin
               s_d.thrSel = pwdata[`PLLSR_BIT_THRSEL];
            end
            `PLLSR_IDX_HOLDOVER: begin
               s_d.readbackOff = pwdata[`PLLSR_BIT_RBDIS];
               s_d.holdEnA     = pwdata[`PLLSR_BIT_HOLDEN];
               s_d.holdEnB     = pwdata[`PLLSR_BIT_HOLDEN2];
            end
            `PLLSR_IDX_MASK: begin
               s_d.mask = pwdata[`PLLSR_NMON-1:0];
            end
            default: begin
               s_d.mask = s_q.mask; // status write ignored
            end
         endcase
      end

      s_d.irq = |(s_d.events & s_d.mask);

      // read data and error are registered in the setup cycle
      if (setup) begin
         s_d.rdata  = `PLLSR_RST_DATA;
         s_d.slvErr = 1'b0;
         if (!aligned) begin
            s_d.slvErr = 1'b1;
         end else begin
            case (idx)
               `PLLSR_IDX_STATUS: begin
                  if (!s_q.readbackOff) begin
                     s_d.rdata = statusWord;
                  end
               end
               `PLLSR_IDX_REFMON: begin
                  s_d.rdata[`PLLSR_BIT_THRSEL] = s_q.thrSel;
               end
               `PLLSR_IDX_HOLDOVER: begin
                  s_d.rdata[`PLLSR_BIT_RBDIS]   = s_q.readbackOff;
                  s_d.rdata[`PLLSR_BIT_HOLDEN]  = s_q.holdEnA;
                  s_d.rdata[`PLLSR_BIT_HOLDEN2] = s_q.holdEnB;
               end
               `PLLSR_IDX_EVENT: begin
                  s_d.rdata[`PLLSR_NMON-1:0] = s_q.events;
               end
               `PLLSR_IDX_MASK: begin
                  s_d.rdata[`PLLSR_NMON-1:0] = s_q.mask;
               end
               default: begin
                  s_d.slvErr = 1'b1;
               end
            endcase
         end
      end
   end

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         s_q.sync1       <= `PLLSR_RST_MON;
         s_q.sync2       <= `PLLSR_RST_MON;
         s_q.sync3       <= `PLLSR_RST_MON;
         s_q.live        <= `PLLSR_RST_MON;
         s_q.events      <= `PLLSR_RST_MON;
         s_q.mask        <= `PLLSR_RST_MASK;
         s_q.holdEnA     <= `PLLSR_RST_BIT;
         s_q.holdEnB     <= `PLLSR_RST_BIT;
         s_q.readbackOff <= `PLLSR_RST_BIT;
         s_q.thrSel      <= `PLLSR_RST_BIT;
         s_q.irq         <= `PLLSR_RST_BIT;
         s_q.rdata       <= `PLLSR_RST_DATA;
         s_q.slvErr      <= `PLLSR_RST_BIT;
      end else begin
         s_q <= s_d;
      end
   end

   assign pready  = psel & penable;
   assign prdata  = s_q.rdata;
   assign pslverr = s_q.slvErr & psel & penable;
   assign irq     = s_q.irq;
   assign ctlOut.holdoverEnable     = s_q.holdEnA & s_q.holdEnB;
   assign ctlOut.refThresholdSelect = s_q.thrSel;

endmodule : pllsr_status
`default_nettype wire

//--- pllsr_status_asserts.sv
// Purpose: port assertions of the pll status bank
// Assumes: zero wait APB, byte address = 4 x index
// Notes:   bound to pllsr_status
`timescale 1ns/10ps
`default_nettype none
module pllsr_status_asserts
   import pllsr_pkg::*;
(
   input wire logic        sys_clk,
   input wire logic        reset,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pslverr,
   input wire pllsrMon_t   monIn,
   input wire pllsrCtl_t   ctlOut,
   input wire logic        irq
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (reset);
   wire logic acc = psel && penable;
   wire logic wr = acc && pwrite;
   wire logic rdSt = acc && !pwrite && paddr == 12'h07C;
   logic      rbOff_q;
   // mirror of the readback disable bit
   always_ff @(posedge sys_clk or posedge reset)
      if (reset)
         rbOff_q <= 1'b0;
      else if (wr && paddr == 12'h074)
         rbOff_q <= pwdata[4];
   hold_en_a: assert property (wr && paddr == 12'h074 |=>
      ctlOut.holdoverEnable == ($past(pwdata[2]) && $past(pwdata[0])))
      else $error("holdover enable wrong");
   thr_sel_a: assert property (wr && paddr == 12'h068 |=>
      ctlOut.refThresholdSelect == $past(pwdata[6]))
      else $error("threshold select wrong");
   live_stat_a: assert property ($stable(monIn) [*6] ##0
      (rdSt && !rbOff_q) |-> prdata == {25'h0, monIn})
      else $error("status not live");
   rb_off_a: assert property (rdSt && rbOff_q |-> prdata == 32'h0)
      else $error("readback not disabled");
   st_upper_a: assert property (rdSt |-> prdata[31:7] == 25'h0)
      else $error("status upper bits set");
   st_noerr_a: assert property (acc && paddr == 12'h07C |-> !pslverr)
      else $error("status access errored");
   bad_addr_a: assert property (acc && (paddr[1:0] != 2'h0
      || paddr[11:2] > 10'h021 || paddr[11:2] < 10'h01A) |-> pslverr)
      else $error("bad address accepted");
   irq_mask_a: assert property (wr && paddr == 12'h084
      && pwdata[6:0] == 7'h00 |=> !irq)
      else $error("irq with zero mask");
   cover property (rdSt && prdata[6]);
   cover property (irq);
   cover property (acc && pslverr);
endmodule : pllsr_status_asserts
bind pllsr_status pllsr_status_asserts chk_u (.sys_clk, .reset, .psel,
   .penable, .pwrite, .paddr, .pwdata, .prdata, .pslverr, .monIn,
   .ctlOut, .irq);
`default_nettype wire

//--- tb_top.sv
// Purpose: self-checking bench of the pll status bank
// Assumes: zero wait APB, status live 4 edges after a change
// Notes:   exMon is the bench model of the monitors
`timescale 1ns/10ps
`default_nettype none
module tb_top
   import pllsr_pkg::*;
;
   logic        sys_clk = 1'b0;
   logic        reset = 1'b1;
   logic        psel, penable, pwrite, pready, pslverr, irq, rdErr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   pllsrMon_t   monIn;
   pllsrCtl_t   ctlOut;
   integer      failures = 0, compares = 0, seed = 10708, i, n, exMon;
   always #2 sys_clk = ~sys_clk;
   pllsr_status dut_u (.sys_clk, .reset, .psel, .penable, .pwrite, .paddr,
      .pwdata, .pready, .prdata, .pslverr, .monIn, .ctlOut, .irq);
   task final_report;
      if (failures == 0 && compares > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : final_report
   task chk(input logic [31:0] g, input logic [31:0] e);
      compares++;
      if (g !== e) begin
         failures++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : chk
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge sys_clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n == 20) begin
         failures++;
         final_report;
      end
      rd = prdata;
      rdErr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge sys_clk);
   endtask : apb
   initial begin
      {psel, penable, pwrite, paddr, pwdata, monIn} = '0;
      repeat (20) @(posedge sys_clk);
      reset <= 1'b0;
      @(posedge sys_clk);
      apb(0, 12'h074, 0); chk(rd, 0);
      for (i = 0; i < 8; i++) begin
         exMon = $random(seed) & 32'h7F;
         monIn <= exMon[6:0];
         repeat (6) @(posedge sys_clk);
         apb(1, 12'h07C, ~exMon); chk(rdErr, 0);
         apb(0, 12'h07C, 0); chk(rd, exMon);
      end
      exMon = exMon | 32'h40;
      monIn <= exMon[6:0];
      for (i = 0; i < 4; i++) begin
         apb(1, 12'h074, {29'h0, i[1], 1'b0, i[0]});
         chk(ctlOut.holdoverEnable, i == 3);
      end
      apb(1, 12'h068, 32'h40); chk(ctlOut.refThresholdSelect, 1);
      apb(1, 12'h068, 32'h0); chk(ctlOut.refThresholdSelect, 0);
      apb(1, 12'h074, 32'h10);
      apb(0, 12'h07C, 0); chk(rd, 0);
      apb(1, 12'h074, 0);
      apb(0, 12'h07C, 0); chk(rd, exMon);
      apb(0, 12'h0FC, 0); chk(rdErr, 1);
      chk(rd, 0);
      apb(0, 12'h07D, 0); chk(rdErr, 1);
      // interrupt raised, masked, cleared
      apb(1, 12'h080, 32'h7F);
      apb(1, 12'h084, 32'h7F); chk(irq, 0);
      exMon = exMon ^ 1;
      monIn <= exMon[6:0];
      repeat (6) @(posedge sys_clk);
      apb(0, 12'h080, 0); chk(irq, 1);
      chk(rd, 1);
      apb(1, 12'h084, 0); chk(irq, 0);
      apb(1, 12'h080, 1);
      apb(1, 12'h084, 32'h7F);
      apb(0, 12'h080, 0); chk(irq, 0);
      chk(rd, 0);
      final_report;
   end
endmodule : tb_top
`default_nettype wire
